// ==== status_flag_logic.sv ====
// How it works
// RULE1: register operations touch only status bits 7, 6, 5, 2, 0.
// RULE2: condition code: zero/equal/all-ones 00, positive/greater 01, negative/less/not-all 10.
// RULE3: half-carry updated by arithmetic and rotate; 1 means carry or no borrow. Rotates update it here only with carry mode (bit 3) set.
// RULE4: overflow on add same-sign operands, sign change; subtract differing signs.
// RULE5: rotate with carry mode sets overflow on plus-to-minus; else leaves it.
// RULE6: carry updated by arithmetic and rotate; 1 carry or no borrow. Rotates update it here only with carry mode (bit 3) set.
// RULE7: test operand is register zero or banked register one to three.
// RULE8: compares change only the condition code.
// RULE9: unsigned-compare bit selects unsigned versus signed compares.
// RULE10: positive is nonzero with msb clear; negative is msb set.
module status_flag_logic
  import flag_pkg::*;
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic EXEC,
  input wire logic [2:0] OP,
  input wire logic [1:0] REG_SEL,
  input wire logic [7:0] OPERAND_A,
  input wire logic [7:0] OPERAND_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic [7:0] LOW_STATUS_WORD,
  output logic [7:0] RESULT,
  output logic [2:0] REG_INDEX
);
  // keeps the bank, mode and compare-select bits out of flag updates
  localparam logic [7:0] FLAG_MASK = 8'hE5;
  logic [7:0] status_q, status_d;
  logic [7:0] result_q, result_d;
  logic [2:0] index_q, index_d;
  logic [2:0] op_q, op_d;
  logic [7:0] opnd_q, opnd_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [7:0] calc_result, calc_status;
  logic [2:0] act_op;
  logic [7:0] act_b;
  logic run;
  logic wb_req, wb_wr, byte0;

  assign wb_req = WB_CYC_I & WB_STB_I & ~ack_q;
  assign wb_wr = wb_req & WB_WE_I;
  assign byte0 = WB_SEL_I[0];
  // a software op trigger runs through the same path as EXEC
  assign run = EXEC | (wb_wr & byte0 & (WB_ADR_I == OFS_OP));
  assign act_op = EXEC ? OP : WB_DAT_I[2:0];
  assign act_b = EXEC ? OPERAND_B : opnd_q;

  flag_calc u_calc (
    .op(act_op),
    .a(EXEC ? OPERAND_A : result_q),
    .b(act_b),
    .status(status_q),
    .result(calc_result),
    .status_next(calc_status)
  );

  // status, result and bus next-state
  always_comb
  begin
    status_d = status_q;
    result_d = result_q;
    index_d = index_q;
    op_d = op_q;
    opnd_d = opnd_q;
    ack_d = wb_req;
    rdat_d = 32'h0000_0000;
    if (run)
    begin
      op_d = act_op;
      // only bits 7,6,5,2,0 move; compares further limited to cc
      if (op_e'(act_op) == OP_COMPARE)
        status_d = {calc_status[7:6], status_q[5:0]}; // RULE8
      else
        status_d = (calc_status & FLAG_MASK) | (status_q & ~FLAG_MASK); // RULE1
      if (op_e'(act_op) != OP_COMPARE && op_e'(act_op) != OP_TEST)
        result_d = calc_result;
    end
    if (EXEC)
    begin
      // register zero is shared, others come from the selected bank
      if (REG_SEL == 2'h0)
        index_d = 3'h0; // RULE7
      else
        index_d = {1'b0, REG_SEL} + (status_q[BANK_SEL_BIT] ? 3'h3 : 3'h0); // RULE7
    end
    else if (wb_wr && byte0)
    begin
      // software writes may set any bit directly
      if (WB_ADR_I == OFS_STATUS)
        status_d = WB_DAT_I[7:0];
      else if (WB_ADR_I == OFS_OPND)
        opnd_d = WB_DAT_I[7:0];
      else if (WB_ADR_I == OFS_RESULT)
        result_d = WB_DAT_I[7:0];
    end
    if (wb_req && !WB_WE_I)
    begin
      unique case (WB_ADR_I)
        OFS_STATUS: rdat_d = {24'h00_0000, status_q};
        OFS_OP: rdat_d = {29'h0000_0000, op_q};
        OFS_OPND: rdat_d = {24'h00_0000, opnd_q};
        OFS_RESULT: rdat_d = {21'h00_0000, index_q, result_q};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end

  // state registers
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      status_q <= STATUS_RESET;
      result_q <= 8'h00;
      index_q <= 3'h0;
      op_q <= 3'h0;
      opnd_q <= 8'h00;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else
    begin
      status_q <= status_d;
      result_q <= result_d;
      index_q <= index_d;
      op_q <= op_d;
      opnd_q <= opnd_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;
  assign LOW_STATUS_WORD = status_q;
  assign RESULT = result_q;
  assign REG_INDEX = index_q;
endmodule

// ==== flag_pkg.sv ====
package flag_pkg;
  // status byte bit positions
  localparam int CC_HI_BIT = 7;
  localparam int CC_LO_BIT = 6;
  localparam int HALF_CARRY_BIT = 5;
  localparam int BANK_SEL_BIT = 4;
  localparam int WITH_CARRY_BIT = 3;
  localparam int OVERFLOW_BIT = 2;
  localparam int UCMP_BIT = 1;
  localparam int CARRY_BIT = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // condition code encodings
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_POS = 2'h1;
  localparam logic [1:0] CC_NEG = 2'h2;
  // wishbone register offsets
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_OP = 4'h4;
  localparam logic [3:0] OFS_OPND = 4'h8;
  localparam logic [3:0] OFS_RESULT = 4'hC;
  // operation classes
  typedef enum logic [2:0] {
    OP_LOAD, OP_ADD, OP_SUB, OP_LOGIC, OP_COMPARE, OP_TEST, OP_ROTL, OP_ROTR
  } op_e;
endpackage

// ==== flag_calc.sv ====
// pure flag computation for one operation
module flag_calc
  import flag_pkg::*;
(
  input wire logic [2:0] op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic [7:0] status,
  output logic [7:0] result,
  output logic [7:0] status_next
);
  logic [8:0] sum;
  logic [4:0] nib;
  logic a_gt, a_eq;
  logic [1:0] cc;

  // arithmetic, compare and test, all from the same operands
  always_comb
  begin
    status_next = status;
    result = a;
    sum = 9'h000;
    nib = 5'h00;
    cc = CC_ZERO;
    a_eq = (a == b);
    if (status[UCMP_BIT])
      a_gt = a > b; // RULE9
    else
      a_gt = $signed(a) > $signed(b); // RULE9
    unique case (op_e'(op))
      OP_ADD:
      begin
        sum = {1'b0, a} + {1'b0, b} + {8'h00, status[WITH_CARRY_BIT] & status[CARRY_BIT]};
        nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, status[WITH_CARRY_BIT] & status[CARRY_BIT]};
        result = sum[7:0];
        status_next[CARRY_BIT] = sum[8]; // RULE6
        status_next[HALF_CARRY_BIT] = nib[4]; // RULE3
        status_next[OVERFLOW_BIT] = (a[7] == b[7]) && (sum[7] != a[7]); // RULE4
      end
      OP_SUB:
      begin
        // borrow-in is the inverse carry when chaining
        sum = {1'b0, a} + {1'b0, ~b} + {8'h00, ~(status[WITH_CARRY_BIT] & ~status[CARRY_BIT])};
        nib = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, ~(status[WITH_CARRY_BIT] & ~status[CARRY_BIT])};
        result = sum[7:0];
        status_next[CARRY_BIT] = sum[8]; // RULE6
        status_next[HALF_CARRY_BIT] = nib[4]; // RULE3
        status_next[OVERFLOW_BIT] = (a[7] != b[7]) && (sum[7] != a[7]); // RULE4
      end
      OP_ROTL, OP_ROTR:
      begin
        if (status[WITH_CARRY_BIT])
        begin
          // rotate through carry; half-carry takes bit 5 of result
          if (op_e'(op) == OP_ROTL)
          begin
            result = {a[6:0], status[CARRY_BIT]};
            status_next[CARRY_BIT] = a[7]; // RULE6
          end
          else
          begin
            result = {status[CARRY_BIT], a[7:1]};
            status_next[CARRY_BIT] = a[0]; // RULE6
          end
          status_next[HALF_CARRY_BIT] = result[5]; // RULE3
          status_next[OVERFLOW_BIT] = ~a[7] & result[7]; // RULE5
        end
        else if (op_e'(op) == OP_ROTL)
          result = {a[6:0], a[7]};
        else
          result = {a[0], a[7:1]};
      end
      OP_LOGIC:
        result = a & b;
      default:
        result = a;
    endcase
    // condition code
    if (op_e'(op) == OP_COMPARE)
      cc = a_eq ? CC_ZERO : (a_gt ? CC_POS : CC_NEG); // RULE8
    else if (op_e'(op) == OP_TEST)
      cc = ((a & b) == b) ? CC_ZERO : CC_NEG; // RULE2
    else if (result == 8'h00)
      cc = CC_ZERO; // RULE2
    else if (result[7])
      cc = CC_NEG; // RULE10
    else
      cc = CC_POS; // RULE10
    status_next[CC_HI_BIT] = cc[1]; // RULE2
    status_next[CC_LO_BIT] = cc[0]; // RULE2
  end
endmodule

// ==== status_flag_logic_props.sv ====
module status_flag_logic_props (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic EXEC,
  input wire logic [2:0] OP,
  input wire logic [7:0] OPERAND_A,
  input wire logic [7:0] OPERAND_B,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic [7:0] LOW_STATUS_WORD,
  input wire logic [7:0] RESULT
);
  logic [7:0] s;
  assign s = LOW_STATUS_WORD;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // operations leave the mode bits alone
  mode_keep_a: assert property (EXEC |=> {s[4:3], s[1]} == $past({s[4:3], s[1]}))
    else $error("mode bit changed");
  cmp_keep_a: assert property (EXEC && OP == 3'h4 |=> {s[5], s[2], s[0]} == $past({s[5], s[2], s[0]}))
    else $error("compare touched flags");
  cmp_equal_a: assert property (EXEC && OP == 3'h4 && OPERAND_A == OPERAND_B |=> s[7:6] == 2'h0)
    else $error("equal compare code");
  mask_cc_a: assert property (EXEC && OP == 3'h5 && (OPERAND_A & OPERAND_B) != OPERAND_B |=> s[7:6] == 2'h2)
    else $error("mask test code");
  // code follows the result just produced
  result_cc_a: assert property (EXEC && OP == 3'h3 |=> s[7:6] == (RESULT == 8'h00 ? 2'h0 : {RESULT[7], !RESULT[7]}))
    else $error("logical result code");
  add_ovf_a: assert property (EXEC && OP == 3'h1 |=> s[2] ==
    ($past(OPERAND_A[7]) == $past(OPERAND_B[7]) && RESULT[7] != $past(OPERAND_A[7]))) else $error("add overflow");
  rot_keep_a: assert property (EXEC && OP[2:1] == 2'h3 && !s[3] |=> s[2] == $past(s[2]))
    else $error("rotate touched overflow");
  // one-cycle acknowledge, then dropped
  ack_pulse_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack timing");
endmodule
bind status_flag_logic status_flag_logic_props i_props (.*);

// ==== status_flag_logic_tb.sv ====
module status_flag_logic_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import flag_pkg::*;
  logic clk = 0, arst_n = 0, exec = 0, req = 0, we = 0, ack;
  logic [2:0] op = 0, o, ri;
  logic [1:0] rsel = 0;
  logic [3:0] adr = 0;
  logic [7:0] opa = 0, opb = 0, av, bv, st, res, sw, ro;
  logic [31:0] wdat = 0, rdat;
  logic [15:0] sq[$];
  logic [7:0] rq[$];
  logic [2:0] iq[$];
  int err_count = 0, comparisons = 0, cyc_n = 0, rnd = 53;
  always #12.5 clk = ~clk;
  status_flag_logic i_dut (.CLK(clk), .ARST_N(arst_n), .EXEC(exec), .OP(op), .REG_SEL(rsel), .OPERAND_A(opa),
    .OPERAND_B(opb), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .LOW_STATUS_WORD(sw), .RESULT(ro), .REG_INDEX(ri));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("mismatches %0d of %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  function int xs(input int x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  // expected status with carry mode off, so no carry in
  function logic [15:0] model(input logic [2:0] c, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] t;
    logic [7:0] v;
    t = c[0] ? a + b : {1'b0, a} - b;
    v = (c == 3'h3) ? a & b : (c == 3'h0) ? a : (c == 3'h6) ? {a[6:0], a[7]} : (c == 3'h7) ? {a[0], a[7:1]} : t[7:0];
    // rotates with carry mode off leave every flag but the code alone
    if (c == 3'h1 || c == 3'h2)
    begin
      st[5] = c[0] ? ({1'b0, a[3:0]} + b[3:0]) > 5'h0F : a[3:0] >= b[3:0];
      st[2] = (c[0] ? a[7] == b[7] : a[7] != b[7]) && v[7] != a[7];
      st[0] = c[0] ? t[8] : !t[8];
    end
    if (c != 3'h4 && c != 3'h5)
      res = v;
    if (c == 3'h4)
      st[7:6] = a == b ? CC_ZERO : (st[1] ? a > b : $signed(a) > $signed(b)) ? CC_POS : CC_NEG;
    else if (c == 3'h5)
      st[7:6] = (a & b) == b ? CC_ZERO : CC_NEG;
    else
      st[7:6] = v == 8'h00 ? CC_ZERO : v[7] ? CC_NEG : CC_POS;
    return {res, st};
  endfunction
  // classic single cycle, held until ack is sampled
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    if (!w)
      rq.push_back(e);
    @(posedge clk);
    req <= 1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk); while (ack !== 1'b1);
    req <= 0;
  endtask
  // watcher pairs each answer with the oldest note
  always @(posedge clk)
  begin
    cyc_n++;
    if (cyc_n > 2000)
    begin
      err_count++;
      wrap_up;
    end
    if (ack === 1'b1 && we === 1'b0)
      chk({8'h00, rdat[7:0]}, {8'h00, rq.pop_front()});
    if (exec === 1'b1)
    begin
      #1 chk({ro, sw}, sq.pop_front());
      chk({13'h0000, ri}, {13'h0000, iq.pop_front()});
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    arst_n <= 1;
    res = 8'h00;
    bus(0, OFS_STATUS, 8'h00, STATUS_RESET);
    bus(0, 4'h2, 8'h00, 8'h00);
    // unsigned then signed compares, ops back to back
    for (int p = 0; p < 2; p++)
    begin
      st = p ? 8'h00 : 8'h12;
      bus(1, OFS_STATUS, st, 8'h00);
      repeat (40)
      begin
        rnd = xs(rnd);
        o = rnd[10:8];
        av = rnd[7:0];
        bv = rnd[20] ? av : rnd[15:8];
        sq.push_back(model(o, av, bv));
        iq.push_back(rnd[17:16] == 2'h0 ? 3'h0 : {1'b0, rnd[17:16]} + (st[4] ? 3'h3 : 3'h0));
        @(posedge clk);
        exec <= 1;
        op <= o;
        opa <= av;
        opb <= bv;
        rsel <= rnd[17:16];
      end
      @(posedge clk);
      exec <= 0;
      bus(0, OFS_STATUS, 8'h00, st);
    end
    wrap_up;
  end
endmodule
